// *** hdl/ashp_buf2.sv ***
// Small valid/ready buffer holding received words for the user side
`timescale 1ns/1ps
module ashp_buf2 #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic [$clog2(DEPTH+1)-1:0] o_level,
  // Drain side
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2) begin : g_bad_depth
    $error("ashp_buf2: DEPTH must be at least 2");
  end

  logic [W-1:0] mem_reg [DEPTH];
  logic [PW-1:0] rd_ptr_reg, rd_ptr_next, wr_ptr_reg, wr_ptr_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic push, pop;

  assign o_in_ready = (cnt_reg != CW'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign o_level = cnt_reg;

  always_comb begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_reg + 1'b1);
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_reg + 1'b1);
    end
    cnt_next = CW'(cnt_reg + CW'(push) - CW'(pop));
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      rd_ptr_reg <= rd_ptr_next;
      wr_ptr_reg <= wr_ptr_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  property p_buf_full_refuses;
    @(posedge i_clk) disable iff (i_rst)
      (cnt_reg == CW'(DEPTH)) && !pop |=> (cnt_reg == CW'(DEPTH));
  endproperty
  a_buf_full_refuses: assert property (p_buf_full_refuses)
    else $error("buffer lost its fill level while full");
endmodule

// *** hdl/ashp_master.sv ***
// Graphics-port master: frame handshake, strobes, sideband and target receive
`timescale 1ns/1ps
module ashp_master #(
  parameter int BLK_WORDS = ashp_pkg::ASHP_BLK_WORDS
) (
  // Core clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // Configuration
  input ashp_pkg::ashp_rate_t I_XFER_RATE,
  input wire logic I_SBA_EN,
  // Command port (length is words minus one)
  input wire logic I_CMD_VALID,
  input wire logic I_CMD_WRITE,
  input wire logic [ashp_pkg::ASHP_AD_W-1:0] I_CMD_ADDR,
  input wire logic [ashp_pkg::ASHP_CBE_W-1:0] I_CMD_CODE_N,
  input wire logic [ashp_pkg::ASHP_LEN_W-1:0] I_CMD_LEN,
  output logic O_CMD_READY,
  output logic O_CMD_DONE,
  // Write data
  input wire logic I_WR_VALID,
  input wire logic [ashp_pkg::ASHP_AD_W-1:0] I_WR_DATA,
  output logic O_WR_READY,
  // Received data
  output logic O_RD_VALID,
  output logic [ashp_pkg::ASHP_AD_W-1:0] O_RD_DATA,
  input wire logic I_RD_READY,
  // Incoming transaction
  output logic O_TGT_START,
  output logic [ashp_pkg::ASHP_AD_W-1:0] O_TGT_ADDR,
  output logic [ashp_pkg::ASHP_CBE_W-1:0] O_TGT_CMD_N,
  // Sideband request
  input wire logic I_SBA_VALID,
  input wire logic [ashp_pkg::ASHP_SBA_W-1:0] I_SBA_DATA,
  output logic O_SBA_READY,
  // Link clock and shared pins
  input wire logic I_AGP_CLK,
  input wire logic [ashp_pkg::ASHP_AD_W-1:0] I_AD,
  output logic [ashp_pkg::ASHP_AD_W-1:0] O_AD,
  output logic O_AD_OE,
  input wire logic [ashp_pkg::ASHP_CBE_W-1:0] I_CBE_N,
  output logic [ashp_pkg::ASHP_CBE_W-1:0] O_CBE_N,
  output logic O_CBE_OE,
  input wire logic I_FRAME_N,
  output logic O_FRAME_N,
  output logic O_FRAME_OE,
  input wire logic I_IRDY_N,
  output logic O_IRDY_N,
  output logic O_IRDY_OE,
  input wire logic I_TRDY_N,
  output logic O_TRDY_N,
  output logic O_TRDY_OE,
  // Strobes
  output logic [1:0] O_AD_STB,
  output logic [1:0] O_AD_STB_OE,
  output logic [1:0] O_AD_STB_N,
  output logic [1:0] O_AD_STB_N_OE,
  output logic O_SB_STB,
  output logic O_SB_STB_OE,
  output logic O_SB_STB_N,
  output logic O_SB_STB_N_OE,
  output logic [ashp_pkg::ASHP_SBA_W-1:0] O_SBA
);
  import ashp_pkg::*;

  if (BLK_WORDS != (1 << ASHP_LEN_W)) begin : g_bad_blk
    $error("ashp_master: BLK_WORDS must match the command length field");
  end

  localparam int CW = ASHP_CNT_W;
  localparam int LW = ASHP_LEN_W;
  localparam int BLW = $clog2(ASHP_BUF_DEPTH + 1);

  // Pin synchroniser; first stage feeds only the second
  logic [ASHP_SYNC_W-1:0] sync1_reg, sync2_reg;
  logic clk_prev_reg;
  logic tick, frame_in, irdy_in, trdy_in;
  logic [ASHP_AD_W-1:0] ad_in;
  logic [ASHP_CBE_W-1:0] cbe_in;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      // Link clock bits rest high so release never fakes a rising edge
      sync1_reg <= {1'b1, 3'h7, ASHP_CBE_RST, ASHP_AD_RST};
      sync2_reg <= {1'b1, 3'h7, ASHP_CBE_RST, ASHP_AD_RST};
      clk_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= {I_AGP_CLK, I_FRAME_N, I_IRDY_N, I_TRDY_N, I_CBE_N, I_AD};
      sync2_reg <= sync1_reg;
      clk_prev_reg <= sync2_reg[ASHP_SYNC_W-1];
    end
  end

  // Act once per rising link clock edge
  assign tick = sync2_reg[ASHP_SYNC_W-1] && !clk_prev_reg;
  assign frame_in = !sync2_reg[ASHP_SYNC_W-2];
  assign irdy_in = !sync2_reg[ASHP_SYNC_W-3];
  assign trdy_in = !sync2_reg[ASHP_SYNC_W-4];
  assign cbe_in = sync2_reg[ASHP_AD_W +: ASHP_CBE_W];
  assign ad_in = sync2_reg[ASHP_AD_W-1:0];

  // Received-word buffer
  logic push;
  logic [ASHP_AD_W-1:0] push_data;
  logic buf_ready;
  logic [BLW-1:0] buf_level;

  ashp_buf2 #(.W(ASHP_AD_W), .DEPTH(ASHP_BUF_DEPTH)) u_rx_buf (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_in_valid(push),
    .i_in_data(push_data),
    .o_in_ready(buf_ready),
    .o_level(buf_level),
    .o_out_valid(O_RD_VALID),
    .o_out_data(O_RD_DATA),
    .i_out_ready(I_RD_READY)
  );

  // Transaction state
  ashp_state_t state_reg, state_next;
  logic wr_reg, wr_next, tlast_reg, tlast_next;
  logic [LW-1:0] len_reg, len_next;
  logic [CW-1:0] idx_reg, idx_next, drain_reg, drain_next;
  logic [ASHP_AD_W-1:0] addr_reg, addr_next, ad_reg, ad_next;
  logic [ASHP_CBE_W-1:0] cmd_reg, cmd_next, cbe_reg, cbe_next;
  logic frame_reg, frame_next, irdy_reg, irdy_next, trdy_reg, trdy_next;
  logic ad_oe_reg, ad_oe_next, ctl_oe_reg, ctl_oe_next, trdy_oe_reg, trdy_oe_next;
  logic done_reg, done_next, tstart_reg, tstart_next;
  logic [ASHP_AD_W-1:0] taddr_reg, taddr_next;
  logic [ASHP_CBE_W-1:0] tcmd_reg, tcmd_next;
  logic [ASHP_AD_W-1:0] blk_mem [BLK_WORDS];
  logic mem_we;
  logic [LW-1:0] mem_wa;
  logic [ASHP_AD_W-1:0] mem_wd;
  logic phase_done, room;
  logic [CW-1:0] cur;

  assign O_CMD_READY = (state_reg == ASHP_S_IDLE) && !(tick && frame_in);
  assign O_WR_READY = (state_reg == ASHP_S_WLOAD);

  always_comb begin
    state_next = state_reg;
    wr_next = wr_reg;
    tlast_next = tlast_reg;
    len_next = len_reg;
    idx_next = idx_reg;
    drain_next = drain_reg;
    addr_next = addr_reg;
    cmd_next = cmd_reg;
    ad_next = ad_reg;
    cbe_next = cbe_reg;
    frame_next = frame_reg;
    irdy_next = irdy_reg;
    trdy_next = trdy_reg;
    ad_oe_next = ad_oe_reg;
    ctl_oe_next = ctl_oe_reg;
    trdy_oe_next = trdy_oe_reg;
    taddr_next = taddr_reg;
    tcmd_next = tcmd_reg;
    done_next = 1'b0;
    tstart_next = 1'b0;
    mem_we = 1'b0;
    mem_wa = idx_reg[LW-1:0];
    mem_wd = ad_in;
    push = 1'b0;
    push_data = ad_in;
    phase_done = 1'b0;
    room = 1'b0;
    cur = idx_reg;
    unique case (state_reg)
      ASHP_S_IDLE: begin
        if (tick && frame_in) begin
          // Incoming access wins over a new command
          taddr_next = ad_in;
          tcmd_next = cbe_in;
          tstart_next = 1'b1;
          idx_next = '0;
          trdy_oe_next = 1'b1;
          trdy_next = 1'b0;
          state_next = ASHP_S_TDATA;
        end else if (I_CMD_VALID) begin
          wr_next = I_CMD_WRITE;
          addr_next = I_CMD_ADDR;
          cmd_next = I_CMD_CODE_N;
          len_next = I_CMD_LEN;
          idx_next = '0;
          state_next = I_CMD_WRITE ? ASHP_S_WLOAD : ASHP_S_ADDR;
        end
      end
      ASHP_S_WLOAD: begin
        // Whole write is held locally before the access starts
        if (I_WR_VALID) begin
          mem_we = 1'b1;
          mem_wd = I_WR_DATA;
          idx_next = CW'(idx_reg + 1'b1);
          if (idx_reg[LW-1:0] == len_reg) begin
            idx_next = '0;
            state_next = ASHP_S_ADDR;
          end
        end
      end
      ASHP_S_ADDR: begin
        if (tick) begin
          frame_next = 1'b1;
          ctl_oe_next = 1'b1;
          irdy_next = 1'b0;
          ad_next = addr_reg;
          ad_oe_next = 1'b1;
          cbe_next = cmd_reg;
          state_next = ASHP_S_IDATA;
        end
      end
      ASHP_S_IDATA: begin
        if (tick) begin
          phase_done = irdy_reg && trdy_in;
          cur = phase_done ? CW'(idx_reg + 1'b1) : idx_reg;
          idx_next = cur;
          if (phase_done && !wr_reg) begin
            push = 1'b1;
          end
          if (phase_done && (idx_reg[LW-1:0] == len_reg)) begin
            frame_next = 1'b0;
            irdy_next = 1'b0;
            ctl_oe_next = 1'b0;
            ad_oe_next = 1'b0;
            done_next = 1'b1;
            state_next = ASHP_S_TURN;
          end else begin
            // Reads wait for room that survives this cycle's push
            room = (BLW'(buf_level + BLW'(push)) < BLW'(ASHP_BUF_DEPTH));
            irdy_next = wr_reg || room;
            frame_next = !((cur[LW-1:0] == len_reg) && (wr_reg || room));
            ad_next = blk_mem[cur[LW-1:0]];
            ad_oe_next = wr_reg;
            cbe_next = ASHP_BE_ALL_N;
          end
        end
      end
      ASHP_S_TDATA: begin
        if (tick) begin
          phase_done = trdy_reg && irdy_in;
          if (phase_done) begin
            mem_we = 1'b1;
            idx_next = CW'(idx_reg + 1'b1);
          end
          if (phase_done && (!frame_in || idx_reg == CW'(BLK_WORDS - 1))) begin
            trdy_next = 1'b0;
            tlast_next = !frame_in;
            drain_next = '0;
            state_next = ASHP_S_TDRAIN;
          end else begin
            trdy_next = 1'b1;
          end
        end
      end
      ASHP_S_TDRAIN: begin
        push_data = blk_mem[drain_reg[LW-1:0]];
        if (drain_reg == idx_reg) begin
          idx_next = '0;
          if (tlast_reg) begin
            trdy_oe_next = 1'b0;
            state_next = ASHP_S_TURN;
          end else begin
            state_next = ASHP_S_TDATA;
          end
        end else if (buf_ready) begin
          push = 1'b1;
          drain_next = CW'(drain_reg + 1'b1);
        end
      end
      ASHP_S_TURN: begin
        // One idle link clock between owners
        if (tick) begin
          state_next = ASHP_S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      state_reg <= ASHP_S_IDLE;
      wr_reg <= 1'b0;
      tlast_reg <= 1'b0;
      len_reg <= '0;
      idx_reg <= '0;
      drain_reg <= '0;
      addr_reg <= ASHP_AD_RST;
      cmd_reg <= ASHP_CBE_RST;
      ad_reg <= ASHP_AD_RST;
      cbe_reg <= ASHP_CBE_RST;
      frame_reg <= 1'b0;
      irdy_reg <= 1'b0;
      trdy_reg <= 1'b0;
      ad_oe_reg <= 1'b0;
      ctl_oe_reg <= 1'b0;
      trdy_oe_reg <= 1'b0;
      done_reg <= 1'b0;
      tstart_reg <= 1'b0;
      taddr_reg <= ASHP_AD_RST;
      tcmd_reg <= ASHP_CBE_RST;
    end else begin
      state_reg <= state_next;
      wr_reg <= wr_next;
      tlast_reg <= tlast_next;
      len_reg <= len_next;
      idx_reg <= idx_next;
      drain_reg <= drain_next;
      addr_reg <= addr_next;
      cmd_reg <= cmd_next;
      ad_reg <= ad_next;
      cbe_reg <= cbe_next;
      frame_reg <= frame_next;
      irdy_reg <= irdy_next;
      trdy_reg <= trdy_next;
      ad_oe_reg <= ad_oe_next;
      ctl_oe_reg <= ctl_oe_next;
      trdy_oe_reg <= trdy_oe_next;
      done_reg <= done_next;
      tstart_reg <= tstart_next;
      taddr_reg <= taddr_next;
      tcmd_reg <= tcmd_next;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (mem_we) begin
      blk_mem[mem_wa] <= mem_wd;
    end
  end

  // Strobes and sideband
  logic stb_reg, stb_next, ad_src_reg, ad_src_next, sb_src_reg, sb_src_next;
  logic [ASHP_SBA_W-1:0] sba_reg, sba_next;
  logic sba_fast;

  assign sba_fast = I_SBA_EN && (I_XFER_RATE != ASHP_X1);
  // Sideband requests never touch frame or the ready lines
  assign O_SBA_READY = tick && I_SBA_EN;

  always_comb begin
    stb_next = sync2_reg[ASHP_SYNC_W-1];
    ad_src_next = ad_oe_next && (I_XFER_RATE != ASHP_X1);
    sb_src_next = sba_fast;
    sba_next = sba_reg;
    if (O_SBA_READY) begin
      sba_next = I_SBA_VALID ? I_SBA_DATA : ASHP_SBA_IDLE;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      stb_reg <= 1'b0;
      ad_src_reg <= 1'b0;
      sb_src_reg <= 1'b0;
      sba_reg <= ASHP_SBA_IDLE;
    end else begin
      stb_reg <= stb_next;
      ad_src_reg <= ad_src_next;
      sb_src_reg <= sb_src_next;
      sba_reg <= sba_next;
    end
  end

  assign O_AD_STB = {stb_reg, stb_reg};
  assign O_AD_STB_N = {!stb_reg, !stb_reg};
  assign O_AD_STB_OE = {2{ad_src_reg}};
  assign O_AD_STB_N_OE = {2{ad_src_reg}};
  assign O_SB_STB = stb_reg;
  assign O_SB_STB_N = !stb_reg;
  assign O_SB_STB_OE = sb_src_reg;
  assign O_SB_STB_N_OE = sb_src_reg;
  assign O_SBA = sba_reg;
  assign O_AD = ad_reg;
  assign O_AD_OE = ad_oe_reg;
  assign O_CBE_N = cbe_reg;
  assign O_CBE_OE = ad_oe_reg || (ctl_oe_reg && !ad_oe_reg);
  assign O_FRAME_N = !frame_reg;
  assign O_FRAME_OE = ctl_oe_reg;
  assign O_IRDY_N = !irdy_reg;
  assign O_IRDY_OE = ctl_oe_reg;
  assign O_TRDY_N = !trdy_reg;
  assign O_TRDY_OE = trdy_oe_reg;
  assign O_CMD_DONE = done_reg;
  assign O_TGT_START = tstart_reg;
  assign O_TGT_ADDR = taddr_reg;
  assign O_TGT_CMD_N = tcmd_reg;

  // Checks
  property p_stb_low;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      ad_oe_reg && (I_XFER_RATE != ASHP_X1) && $stable(I_XFER_RATE) |-> O_AD_STB_OE[0];
  endproperty
  a_stb_low: assert property (p_stb_low) else $error("low strobe idle while sourcing");
  property p_stb_high;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      O_AD_STB_OE[1] |-> O_AD_STB_OE[0] && (O_AD_STB[1] == O_AD_STB[0]);
  endproperty
  a_stb_high: assert property (p_stb_high) else $error("high strobe not paired with low");
  property p_src_only;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      O_AD_STB_OE[0] |-> !O_TRDY_OE && ad_oe_reg;
  endproperty
  a_src_only: assert property (p_src_only) else $error("strobe driven while receiving");
  property p_stb_pair;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      O_AD_STB_OE[0] |-> O_AD_STB_N_OE[0] && (O_AD_STB_N[0] != O_AD_STB[0]);
  endproperty
  a_stb_pair: assert property (p_stb_pair) else $error("strobe complement not paired");
  property p_sb_pair;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      O_SB_STB_OE |-> O_SB_STB_N_OE && (O_SB_STB_N != O_SB_STB) && $past(I_SBA_EN);
  endproperty
  a_sb_pair: assert property (p_sb_pair) else $error("sideband strobe pair broken");
  property p_frame_only_framed;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      frame_reg |-> (state_reg == ASHP_S_IDATA) && ctl_oe_reg;
  endproperty
  a_frame_only_framed: assert property (p_frame_only_framed) else $error("frame out of access");
  property p_no_wr_wait;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      wr_reg && $fell(irdy_reg) |-> (state_reg == ASHP_S_TURN) && done_reg;
  endproperty
  a_no_wr_wait: assert property (p_no_wr_wait) else $error("write wait state inserted");
  property p_trdy_block;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      $rose(trdy_reg) |-> (idx_reg == '0) && (state_reg == ASHP_S_TDATA);
  endproperty
  a_trdy_block: assert property (p_trdy_block) else $error("target ready without block room");
  property p_phase_end;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      tick && (state_reg == ASHP_S_IDATA) && irdy_reg && trdy_in
        && (idx_reg[LW-1:0] == len_reg) |=> done_reg ##1 !done_reg;
  endproperty
  a_phase_end: assert property (p_phase_end) else $error("final phase not completed");
  property p_phase_wait;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      tick && (state_reg == ASHP_S_IDATA) && !(irdy_reg && trdy_in) |=> $stable(idx_reg);
  endproperty
  a_phase_wait: assert property (p_phase_wait) else $error("phase advanced without both readies");
  c_write: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) done_reg && wr_reg);
  c_read: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) done_reg && !wr_reg);
  c_tgt_blk: cover property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (state_reg == ASHP_S_TDRAIN) && !tlast_reg);
endmodule

// *** hdl/ashp_pkg.sv ***
// Shared constants and types for the graphics-port master controller
package ashp_pkg;
  localparam int ASHP_AD_W = 32;
  localparam int ASHP_CBE_W = 4;
  localparam int ASHP_SBA_W = 8;
  // 32-byte block of 4-byte words
  localparam int ASHP_BLK_BYTES = 32;
  localparam int ASHP_WORD_BYTES = 4;
  localparam int ASHP_BLK_WORDS = ASHP_BLK_BYTES / ASHP_WORD_BYTES;
  localparam int ASHP_LEN_W = $clog2(ASHP_BLK_WORDS);
  localparam int ASHP_CNT_W = $clog2(ASHP_BLK_WORDS + 1);
  localparam int ASHP_BUF_DEPTH = 2;
  localparam int ASHP_SYNC_W = 1 + 3 + ASHP_CBE_W + ASHP_AD_W;
  // Reset and idle values, plus the all-bytes-enabled code for data phases
  localparam logic [ASHP_CBE_W-1:0] ASHP_BE_ALL_N = 4'h0;
  localparam logic [ASHP_CBE_W-1:0] ASHP_CBE_RST = 4'hf;
  localparam logic [ASHP_AD_W-1:0] ASHP_AD_RST = 32'h0000_0000;
  localparam logic [ASHP_SBA_W-1:0] ASHP_SBA_IDLE = 8'hff;

  typedef enum logic [1:0] {ASHP_X1, ASHP_X2, ASHP_X4} ashp_rate_t;

  typedef enum logic [2:0] {
    ASHP_S_IDLE, ASHP_S_WLOAD, ASHP_S_ADDR, ASHP_S_IDATA,
    ASHP_S_TDATA, ASHP_S_TDRAIN, ASHP_S_TURN
  } ashp_state_t;
endpackage

// *** test/agp_strobe_and_handshake_port_test.sv ***
// Self-checking bench for the graphics-port master controller
`timescale 1ns/1ps
module agp_strobe_and_handshake_port_test;
  import ashp_pkg::*;
  logic clk = 1'b0;
  logic agp = 1'b0;
  logic rst = 1'b1;
  logic mon = 1'b0;
  logic stall = 1'b0;
  ashp_rate_t rate = ASHP_X1;
  logic sba_en = 1'b0, cmd_v = 1'b0, cmd_w = 1'b0, wr_v = 1'b0, rd_rdy = 1'b1, sba_v = 1'b0;
  logic [31:0] cmd_a = '0, wr_d = '0, go_a = '0;
  logic [3:0] cmd_c = 4'hf, go_l = 4'h1;
  logic [2:0] cmd_l = '0;
  logic [7:0] sba_d = '0;
  logic go = 1'b0;
  logic cmd_rdy, done, wr_rdy, rd_v, tstart, sba_rdy, ad_oe, cbe_oe, o_fr, fr_oe, o_ir, ir_oe;
  logic o_tr, tr_oe, sb, sb_oe, sbn, sbn_oe, m_fr, m_ir, m_tr, m_ctl_oe, m_tr_oe, m_ad_oe;
  logic [31:0] rd_d, taddr, o_ad, m_ad, w_ad;
  logic [31:0] noise = 32'h5555_aaaa;
  logic [3:0] tcmd, o_cbe, m_cbe, w_cbe;
  logic [1:0] stb, stb_oe, stbn, stbn_oe;
  logic [7:0] sba;
  logic w_fr, w_ir, w_tr;
  logic [31:0] rq[$];
  int checks = 0;
  int n_errors = 0;

  always #25 clk = ~clk;
  initial begin
    #7;
    forever #200 agp = ~agp;
  end
  always @(posedge clk) noise <= ~noise;
  // Released control lines rest on pull-ups; a released data bus toggles
  assign w_fr = fr_oe ? o_fr : m_ctl_oe ? m_fr : 1'b1;
  assign w_ir = ir_oe ? o_ir : m_ctl_oe ? m_ir : 1'b1;
  assign w_tr = tr_oe ? o_tr : m_tr_oe ? m_tr : 1'b1;
  assign w_ad = ad_oe ? o_ad : m_ad_oe ? m_ad : noise;
  assign w_cbe = cbe_oe ? o_cbe : m_ctl_oe ? m_cbe : noise[3:0];

  ashp_master u_dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_XFER_RATE(rate), .I_SBA_EN(sba_en),
    .I_CMD_VALID(cmd_v), .I_CMD_WRITE(cmd_w), .I_CMD_ADDR(cmd_a), .I_CMD_CODE_N(cmd_c),
    .I_CMD_LEN(cmd_l), .O_CMD_READY(cmd_rdy), .O_CMD_DONE(done), .I_WR_VALID(wr_v),
    .I_WR_DATA(wr_d), .O_WR_READY(wr_rdy), .O_RD_VALID(rd_v), .O_RD_DATA(rd_d),
    .I_RD_READY(rd_rdy), .O_TGT_START(tstart), .O_TGT_ADDR(taddr), .O_TGT_CMD_N(tcmd),
    .I_SBA_VALID(sba_v), .I_SBA_DATA(sba_d), .O_SBA_READY(sba_rdy), .I_AGP_CLK(agp),
    .I_AD(w_ad), .O_AD(o_ad), .O_AD_OE(ad_oe), .I_CBE_N(w_cbe), .O_CBE_N(o_cbe),
    .O_CBE_OE(cbe_oe), .I_FRAME_N(w_fr), .O_FRAME_N(o_fr), .O_FRAME_OE(fr_oe),
    .I_IRDY_N(w_ir), .O_IRDY_N(o_ir), .O_IRDY_OE(ir_oe), .I_TRDY_N(w_tr), .O_TRDY_N(o_tr),
    .O_TRDY_OE(tr_oe), .O_AD_STB(stb), .O_AD_STB_OE(stb_oe), .O_AD_STB_N(stbn),
    .O_AD_STB_N_OE(stbn_oe), .O_SB_STB(sb), .O_SB_STB_OE(sb_oe), .O_SB_STB_N(sbn),
    .O_SB_STB_N_OE(sbn_oe), .O_SBA(sba));

  ashp_gfx u_gfx (
    .clk(agp), .slow(stall), .go(go), .go_a(go_a), .go_l(go_l), .frame_n(w_fr),
    .irdy_n(w_ir), .trdy_n(w_tr), .ad(w_ad), .cbe_n(w_cbe), .m_fr(m_fr), .m_ir(m_ir),
    .m_tr(m_tr), .m_ctl_oe(m_ctl_oe), .m_tr_oe(m_tr_oe), .m_ad(m_ad), .m_ad_oe(m_ad_oe),
    .m_cbe(m_cbe));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Receiver stalls at random so the two-entry buffer fills
  always @(negedge clk) rd_rdy <= stall ? 1'($urandom_range(1)) : 1'b1;
  always @(posedge clk) if (rd_v === 1'b1 && rd_rdy) rq.push_back(rd_d);

  always @(posedge clk) begin
    if (mon) begin
      chk({stbn_oe, stbn & stb_oe}, {stb_oe, ~stb & stb_oe});
      chk(stb_oe, {2{ad_oe & (rate != ASHP_X1)}});
      chk(m_ad_oe & (ad_oe | (|stb_oe)), 1'b0);
      chk({sbn_oe, sb_oe & ~(sba_en & (rate != ASHP_X1)), sbn & sb_oe},
          {sb_oe, 1'b0, ~sb & sb_oe});
    end
  end

  task automatic run(input logic w, input logic [31:0] a, input logic [2:0] l);
    rq.delete();
    u_gfx.wq.delete();
    @(negedge clk);
    cmd_v = 1'b1;
    cmd_w = w;
    cmd_a = a;
    cmd_c = w ? 4'h7 : 4'h6;
    cmd_l = l;
    while (cmd_rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_v = 1'b0;
    for (int i = 0; i <= int'(l) && w; i++) begin
      wr_v = 1'b1;
      wr_d = a ^ 32'(i);
      while (wr_rdy !== 1'b1) @(negedge clk);
      @(negedge clk);
    end
    wr_v = 1'b0;
    while (done !== 1'b1) @(negedge clk);
    for (int n = 0; n < 400 && (w ? u_gfx.wq.size() : rq.size()) <= int'(l); n++) @(negedge clk);
    chk(u_gfx.cap_a, a);
    chk(u_gfx.cap_c, cmd_c);
    chk(w ? u_gfx.wq.size() : rq.size(), 32'(l) + 1);
    for (int i = 0; i <= int'(l) && i < (w ? u_gfx.wq.size() : rq.size()); i++)
      chk(w ? u_gfx.wq[i] : rq[i], w ? a ^ 32'(i) : a + 32'(4 * i));
  endtask

  task automatic tgt(input logic [31:0] a, input logic [3:0] l);
    rq.delete();
    @(negedge clk);
    go_a = a;
    go_l = l;
    go = 1'b1;
    for (int n = 0; n < 400 && tstart !== 1'b1; n++) @(negedge clk);
    go = 1'b0;
    chk(tstart, 1'b1);
    chk(taddr, a);
    chk(tcmd, 4'h7);
    for (int n = 0; n < 2000 && rq.size() < int'(l); n++) @(negedge clk);
    chk(rq.size(), 32'(l));
    for (int i = 0; i < rq.size(); i++) chk(rq[i], a + 32'(4 * i));
    while (u_gfx.st != 2'd0) @(negedge clk);
  endtask

  task automatic sbt(input logic [7:0] d);
    @(negedge clk);
    sba_v = 1'b1;
    sba_d = d;
    while (sba_rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    sba_v = 1'b0;
    chk(sba, d);
    chk({fr_oe, ir_oe, tr_oe}, 3'b000);
    chk({sb_oe, sbn_oe}, {2{rate != ASHP_X1}});
  endtask

  initial begin
    void'($urandom(79333));
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int r = 0; r < 3; r++) begin
      mon = 1'b0;
      rate = ashp_rate_t'(r);
      sba_en = (r != 2);
      stall = (r != 0);
      repeat (4) @(negedge clk);
      mon = 1'b1;
      run(1'b0, 32'h0000_0100, 3'h7);
      run(1'b1, $urandom, 3'h0);
      repeat (3) run(1'($urandom_range(1)), $urandom, 3'($urandom_range(7)));
      tgt($urandom, 4'ha);
      tgt($urandom, 4'h1);
      if (sba_en) sbt(8'($urandom));
    end
    summarize();
  end

  initial begin
    #2000000;
    n_errors++;
    summarize();
  end
endmodule

// *** test/ashp_gfx.sv ***
// Graphics master model: target for hub accesses and burst write initiator
`timescale 1ns/1ps
module ashp_gfx (
  // Link clock and test controls
  input wire logic clk,
  input wire logic slow,
  input wire logic go,
  input wire logic [31:0] go_a,
  input wire logic [3:0] go_l,
  // Resolved pins
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  // Driven pins
  output logic m_fr = 1'b1,
  output logic m_ir = 1'b1,
  output logic m_tr = 1'b1,
  output logic m_ctl_oe = 1'b0,
  output logic m_tr_oe = 1'b0,
  output logic [31:0] m_ad = '0,
  output logic m_ad_oe = 1'b0,
  output logic [3:0] m_cbe = 4'hf
);
  logic [1:0] st = 2'd0;
  logic wr = 1'b0;
  logic fin = 1'b0;
  logic stl;
  int idx = 0;
  logic [31:0] cap_a = '0;
  logic [3:0] cap_c = '0;
  logic [31:0] wq[$];

  always @(posedge clk) begin
    case (st)
      2'd0: begin
        fin = 1'b0;
        idx = 0;
        if (go) begin
          m_fr <= 1'b0;
          m_ctl_oe <= 1'b1;
          m_ad <= go_a;
          m_ad_oe <= 1'b1;
          m_cbe <= 4'h7;
          st <= 2'd3;
        end else if (!frame_n) begin
          cap_a <= ad;
          cap_c <= cbe_n;
          wr = cbe_n[0];
          st <= 2'd1;
        end
      end
      2'd1: begin
        // Turnaround cycle before any read data
        // Ready starts deasserted; last burst left it asserted
        m_tr <= 1'b1;
        m_tr_oe <= 1'b1;
        st <= 2'd2;
      end
      2'd2: begin
        if (fin) begin
          m_tr_oe <= 1'b0;
          m_ad_oe <= 1'b0;
          st <= 2'd0;
        end else begin
          stl = slow & 1'($urandom_range(1));
          m_tr <= stl;
          if (!wr) begin
            m_ad <= cap_a + 32'(4 * idx);
            m_ad_oe <= 1'b1;
          end
          if (!stl && !irdy_n) begin
            if (wr) wq.push_back(ad);
            fin = frame_n;
            idx++;
          end
        end
      end
      default: begin
        if (fin) begin
          m_ctl_oe <= 1'b0;
          m_ad_oe <= 1'b0;
          m_fr <= 1'b1;
          m_ir <= 1'b1;
          st <= 2'd0;
        end else begin
          // Whole burst is held ready, so this initiator never inserts a wait state
          m_ir <= 1'b0;
          m_ad <= go_a + 32'(4 * idx);
          m_cbe <= 4'h0;
          m_fr <= (idx == int'(go_l) - 1);
          if (!trdy_n) begin
            fin = (idx == int'(go_l) - 1);
            idx++;
          end
        end
      end
    endcase
  end
endmodule
